// >>> dtc_pkg.sv
// How it works
// - 16-bit counter, counts down only
// - compare relations LT, LTE, EQ, GTE, GT
// - reload period on start, reset, terminal
// - irq on terminal, compare, capture, combos
// - one shot halts after one period
// - gated mode counts only while enabled
// - run modes free, one shot, gated
// - kill forces pwm outputs inactive
// - capture stores full count value
// - complementary outputs never active together
// - compare and terminal outputs, terminal selectable
// - reset input restarts, capture input provided
// - counting clock chosen from several sources
package dtc_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_COMPARE = 8'h08;
  localparam logic [7:0] ADDR_DEADBAND = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_CAPTURE = 8'h14;
  localparam logic [7:0] ADDR_INT_STAT = 8'h18;
  localparam logic [7:0] ADDR_INT_MASK = 8'h1C;
  localparam logic [7:0] ADDR_PRESCALE = 8'h20;
  // ----------------------------------------
  // widths and reset values
  // ----------------------------------------
  localparam int CNT_W = 16;
  localparam int DB_W = 8;
  localparam int CTRL_W = 10;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] COMPARE_RST = 16'h8000;
  localparam logic [7:0] DEADBAND_RST = 8'h00;
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  // interrupt bit positions
  localparam int IRQ_TC = 0;
  localparam int IRQ_CMP = 1;
  localparam int IRQ_CAP = 2;
  localparam int IRQ_W = 3;
  // run modes
  typedef enum logic [1:0] {
    DTC_FREE = 2'h0, DTC_ONESHOT = 2'h1, DTC_GATED = 2'h2
  } dtc_mode_t;
  // compare relations
  typedef enum logic [2:0] {
    DTC_LT = 3'h0, DTC_LTE = 3'h1, DTC_EQ = 3'h2,
    DTC_GTE = 3'h3, DTC_GT = 3'h4
  } dtc_rel_t;
  // counting clock sources
  typedef enum logic [1:0] {
    DTC_SRC_PCLK = 2'h0, DTC_SRC_DIV = 2'h1,
    DTC_SRC_EXT_RISE = 2'h2, DTC_SRC_EXT_FALL = 2'h3
  } dtc_src_t;
  // control register layout, msb first
  typedef struct packed {
    dtc_src_t src;   // [9:8]
    logic tc_cmpl;   // [7]
    logic cap_en;    // [6]
    dtc_rel_t rel;   // [5:3]
    dtc_mode_t mode; // [2:1]
    logic run;       // [0]
  } dtc_ctrl_t;
  localparam logic [9:0] CTRL_RST = 10'h000;
  // routed inputs, order of the sync vector
  typedef struct packed {
    logic ext_clk;
    logic kill;
    logic cap;
    logic rst;
    logic en;
  } dtc_pins_t;
  localparam int PINS_W = 5;
endpackage : dtc_pkg

// >>> dtc_top.sv
`timescale 1ns/1ps
module dtc_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // routed inputs, asynchronous
  input wire dtc_pkg::dtc_pins_t pins,
  // routed outputs
  output logic cmp_out,
  output logic tc_out,
  output logic irq
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [4:0] s1_q;  // first stage, read by s2 only
  logic [4:0] s2_q;  // second stage
  logic [4:0] s3_q;  // third stage
  logic [4:0] flt_q; // accepted level
  dtc_pkg::dtc_pins_t in_s; // accepted inputs
  dtc_pkg::dtc_pins_t in_p; // previous accepted

  // three flops per input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      s3_q <= 5'h00;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < dtc_pkg::PINS_W; gi++) begin : g_flt
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flt_q[gi] <= 1'b0;
        end else if (s2_q[gi] == s3_q[gi]) begin
          flt_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  logic [4:0] prev_q; // accepted level one cycle back

  // edge detect history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 5'h00;
    end else begin
      prev_q <= flt_q;
    end
  end

  assign in_s = flt_q;
  assign in_p = prev_q;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  dtc_pkg::dtc_ctrl_t ctrl_q;   // control
  logic [15:0] period_q;        // reload value
  logic [15:0] compare_q;       // threshold
  logic [7:0] db_q;             // deadband ticks
  logic [7:0] pre_q;            // divider setting
  logic [2:0] mask_q;           // interrupt mask
  logic [2:0] stat_q;           // sticky events
  logic [15:0] cnt_q;           // counter
  logic [15:0] cap_q;           // capture holding
  logic wr_en;                  // write in access phase
  logic rd_setup;               // setup cycle

  assign wr_en = psel & penable & pready & pwrite;
  assign rd_setup = psel & ~penable;

  // software written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= dtc_pkg::CTRL_RST;
      period_q <= dtc_pkg::PERIOD_RST;
      compare_q <= dtc_pkg::COMPARE_RST;
      db_q <= dtc_pkg::DEADBAND_RST;
      pre_q <= dtc_pkg::PRESCALE_RST;
      mask_q <= 3'h0;
    end else if (wr_en) begin
      case (paddr)
        dtc_pkg::ADDR_CTRL: ctrl_q <= pwdata[9:0];
        dtc_pkg::ADDR_PERIOD: period_q <= pwdata[15:0];
        dtc_pkg::ADDR_COMPARE: compare_q <= pwdata[15:0];
        dtc_pkg::ADDR_DEADBAND: db_q <= pwdata[7:0];
        dtc_pkg::ADDR_PRESCALE: pre_q <= pwdata[7:0];
        dtc_pkg::ADDR_INT_MASK: mask_q <= pwdata[2:0];
        default: ; // read only, write one to clear, or unmapped
      endcase
    end
  end

  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  logic [31:0] rd_mux; // read data for address
  logic hit;           // address is mapped

  // read decode
  always_comb begin
    rd_mux = 32'h00000000;
    hit = 1'b1;
    case (paddr)
      dtc_pkg::ADDR_CTRL: rd_mux = {22'h0, ctrl_q};
      dtc_pkg::ADDR_PERIOD: rd_mux = {16'h0000, period_q};
      dtc_pkg::ADDR_COMPARE: rd_mux = {16'h0000, compare_q};
      dtc_pkg::ADDR_DEADBAND: rd_mux = {24'h000000, db_q};
      // live count, reading has no side effect
      dtc_pkg::ADDR_COUNT: rd_mux = {16'h0000, cnt_q};
      dtc_pkg::ADDR_CAPTURE: rd_mux = {16'h0000, cap_q};
      dtc_pkg::ADDR_INT_STAT: rd_mux = {29'h0, stat_q};
      dtc_pkg::ADDR_INT_MASK: rd_mux = {29'h0, mask_q};
      dtc_pkg::ADDR_PRESCALE: rd_mux = {24'h000000, pre_q};
      default: hit = 1'b0;
    endcase
  end

  // answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= rd_setup;
      pslverr <= rd_setup & ~hit;
      if (rd_setup && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // counting clock selection
  // ----------------------------------------
  logic [7:0] div_q; // prescaler count
  logic div_tick;    // prescaler wrap
  logic src_tick;    // selected counting clock

  assign div_tick = (div_q == pre_q);

  // prescaler runs free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
    end else if (div_tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // pick the source of counting ticks
  always_comb begin
    case (ctrl_q.src)
      dtc_pkg::DTC_SRC_PCLK: src_tick = 1'b1;
      dtc_pkg::DTC_SRC_DIV: src_tick = div_tick;
      dtc_pkg::DTC_SRC_EXT_RISE: src_tick = in_s.ext_clk & ~in_p.ext_clk;
      dtc_pkg::DTC_SRC_EXT_FALL: src_tick = ~in_s.ext_clk & in_p.ext_clk;
      default: src_tick = 1'b0;
    endcase
  end

  // ----------------------------------------
  // counter core
  // ----------------------------------------
  logic run_p_q;  // run bit one cycle back
  logic active_q; // counting, cleared by one shot end
  logic start;    // run bit rising
  logic rst_ev;   // reset input rising
  logic cap_ev;   // capture input rising
  logic tick;     // qualified counting tick
  logic tc;       // terminal count this tick

  assign start = ctrl_q.run & ~run_p_q;
  assign rst_ev = in_s.rst & ~in_p.rst;
  assign cap_ev = in_s.cap & ~in_p.cap;
  // gated mode qualifies ticks with enable
  assign tick = src_tick & ctrl_q.run & active_q
    & ((ctrl_q.mode != dtc_pkg::DTC_GATED) | in_s.en);
  // zero reached on a tick
  assign tc = tick & (cnt_q == 16'h0000);

  // run history for start detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_p_q <= 1'b0;
    end else begin
      run_p_q <= ctrl_q.run;
    end
  end

  // one shot stops after its terminal count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= 1'b0;
    end else if (start || rst_ev) begin
      active_q <= 1'b1;
    end else if (tc && ctrl_q.mode == dtc_pkg::DTC_ONESHOT) begin
      active_q <= 1'b0;
    end
  end

  // down counter with period reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= dtc_pkg::PERIOD_RST;
    end else if (start || rst_ev) begin
      cnt_q <= period_q;
    end else if (tc) begin
      cnt_q <= period_q;
    end else if (tick) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  // capture holding register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_q <= 16'h0000;
    end else if (cap_ev && ctrl_q.cap_en) begin
      cap_q <= cnt_q;
    end
  end

  // ----------------------------------------
  // comparator and deadband
  // ----------------------------------------
  logic cmp_raw;    // relation holds
  logic cmp_p_q;    // relation one cycle back
  logic [7:0] dbc_q; // deadband remaining
  logic cmp_rise;   // compare became true

  // selectable relation
  always_comb begin
    case (ctrl_q.rel)
      dtc_pkg::DTC_LT: cmp_raw = cnt_q < compare_q;
      dtc_pkg::DTC_LTE: cmp_raw = cnt_q <= compare_q;
      dtc_pkg::DTC_EQ: cmp_raw = cnt_q == compare_q;
      dtc_pkg::DTC_GTE: cmp_raw = cnt_q >= compare_q;
      dtc_pkg::DTC_GT: cmp_raw = cnt_q > compare_q;
      default: cmp_raw = 1'b0;
    endcase
  end

  assign cmp_rise = cmp_raw & ~cmp_p_q;

  // relation history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_p_q <= 1'b0;
    end else begin
      cmp_p_q <= cmp_raw;
    end
  end

  // every transition opens a gap of db_q ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbc_q <= 8'h00;
    end else if (cmp_raw != cmp_p_q) begin
      dbc_q <= db_q;
    end else if (src_tick && dbc_q != 8'h00) begin
      dbc_q <= dbc_q - 8'h01;
    end
  end

  logic gap; // deadband still running
  assign gap = (cmp_raw != cmp_p_q) | (dbc_q != 8'h00);

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // tc_out itself is the registered terminal pulse, one pclk wide,
  // so no separate pulse register is kept
  // kill leaves that pulse alone and only quiets the compare phases
  // both phases idle through gap and kill
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_out <= 1'b0;
      tc_out <= 1'b0;
    end else if (in_s.kill) begin
      cmp_out <= 1'b0;
      tc_out <= ctrl_q.tc_cmpl ? 1'b0 : tc;
    end else begin
      cmp_out <= cmp_raw & ~gap;
      tc_out <= ctrl_q.tc_cmpl ? (~cmp_raw & ~gap) : tc;
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic [2:0] ev;     // events this cycle
  logic [2:0] clr;    // write one to clear
  logic [2:0] stat_d; // next status

  assign ev[dtc_pkg::IRQ_TC] = tc;
  assign ev[dtc_pkg::IRQ_CMP] = cmp_rise;
  assign ev[dtc_pkg::IRQ_CAP] = cap_ev & ctrl_q.cap_en;
  assign clr = (wr_en && paddr == dtc_pkg::ADDR_INT_STAT) ? pwdata[2:0] : 3'h0;
  // a new event wins over its clear
  assign stat_d = (stat_q & ~clr) | ev;

  // sticky status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 3'h0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // masked level request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_d & mask_q);
    end
  end
endmodule : dtc_top

// >>> dtc_top_assertions.sv
`timescale 1ns/1ps
module dtc_top_assertions (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // routed pins and outputs
  input wire dtc_pkg::dtc_pins_t pins,
  input wire logic cmp_out,
  input wire logic tc_out,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of the complementary select bit
  logic cmpl_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpl_q <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == dtc_pkg::ADDR_CTRL) begin
      cmpl_q <= pwdata[7];
    end
  end
  // setup phase of a transfer
  sequence setup_s;
    psel && !penable;
  endsequence
  // completed read access
  sequence rd_access_s;
    psel && penable && pready && !pwrite;
  endsequence
  a_ready_after_setup: assert property (setup_s |=> pready)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_cause: assert property ($rose(pready) |-> $past(psel && !penable))
    else $error("ready without setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_zero: assert property (rd_access_s ##0 pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_prdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  a_kill_forces_low: assert property (pins.kill [*8] |-> !cmp_out)
    else $error("compare high under kill");
  a_cmpl_exclusive: assert property (cmpl_q && $past(cmpl_q, 2) |-> !(cmp_out && tc_out))
    else $error("both outputs active");
  // a status clear drops irq one cycle after the write, a mask write two cycles after
  a_irq_falls_write: assert property ($fell(irq) |-> $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
    else $error("irq fell without write");
endmodule : dtc_top_assertions
bind dtc_top dtc_top_assertions u_dtc_top_assertions (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pins(pins), .cmp_out(cmp_out), .tc_out(tc_out), .irq(irq));

// >>> dtc_route_model.sv
`timescale 1ns/1ps
module dtc_route_model (
  // clock
  input wire logic pclk,
  // routed levels toward the timer, ext clock toggled through pulse like the cap and reset pins
  output dtc_pkg::dtc_pins_t pins
);
  initial pins = '0;
  // set one pin level just after a rising edge
  task automatic put(input int idx, input logic v);
    @(posedge pclk);
    pins[idx] <= v;
  endtask : put
  // pulse held long enough to pass the synchronizer
  task automatic pulse(input int idx);
    put(idx, 1'b1);
    repeat (6) @(posedge pclk);
    pins[idx] <= 1'b0;
  endtask : pulse
endmodule : dtc_route_model

// >>> down_timer_counter_pwm16_tb.sv
`timescale 1ns/1ps
module down_timer_counter_pwm16_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic err_q;
  dtc_pkg::dtc_pins_t pins;
  logic cmp_out;
  logic tc_out;
  logic irq;
  int miscompares = 0;
  int checks = 0;
  always #5 pclk = ~pclk;
  dtc_top u_dtc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .cmp_out(cmp_out), .tc_out(tc_out), .irq(irq));
  dtc_route_model u_dtc_route_model (.pclk(pclk), .pins(pins));
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff pready);
    d = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    xfer(1'b1, a, wd, d);
  endtask : wr
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // restart with run low then high so the period reloads
  task automatic start(input logic [1:0] m, input logic [2:0] r, input logic cap, input logic cmpl);
    wr(dtc_pkg::ADDR_CTRL, 32'h0);
    wr(dtc_pkg::ADDR_CTRL, {22'h0, 2'h0, cmpl, cap, r, m, 1'b1});
  endtask : start
  function automatic logic relv(input logic [2:0] r, input logic [15:0] c, input logic [15:0] v);
    case (r)
      3'h0: relv = c < v;
      3'h1: relv = c <= v;
      3'h2: relv = c == v;
      3'h3: relv = c >= v;
      default: relv = c > v;
    endcase
  endfunction : relv
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    xfer(1'b0, dtc_pkg::ADDR_PERIOD, 32'h0, d);
    chk("period reset", 32'h0000FFFF, d);
    wr(dtc_pkg::ADDR_COUNT, 32'h1234);
    xfer(1'b0, dtc_pkg::ADDR_COUNT, 32'h0, d);
    chk("count read only", 32'h0000FFFF, d);
    xfer(1'b0, 8'h40, 32'h0, d);
    chk("unmapped data", 32'h0, d);
    chk("unmapped error", 32'h1, {31'h0, err_q});
  endtask : t_regs
  // gated with enable low freezes count at period, so each relation is static
  task automatic t_rel();
    logic e;
    wr(dtc_pkg::ADDR_PERIOD, 32'h10);
    for (int r = 0; r < 5; r++) begin
      for (int k = 0; k < 3; k++) begin
        wr(dtc_pkg::ADDR_COMPARE, 32'hF + k);
        start(dtc_pkg::DTC_GATED, r[2:0], 1'b0, 1'b1);
        repeat (6) @(negedge pclk);
        e = relv(r[2:0], 16'h10, 16'hF + k[15:0]);
        chk("compare out", {31'h0, e}, {31'h0, cmp_out});
        chk("complement out", {31'h0, ~e}, {31'h0, tc_out});
      end
    end
    wr(dtc_pkg::ADDR_COMPARE, 32'hF);
    start(dtc_pkg::DTC_GATED, 3'h4, 1'b0, 1'b1);
    u_dtc_route_model.put(3, 1'b1);
    repeat (10) @(negedge pclk);
    chk("killed compare", 32'h0, {31'h0, cmp_out});
    // less than is false at the held count, so only the complement would be active
    start(dtc_pkg::DTC_GATED, 3'h0, 1'b0, 1'b1);
    repeat (6) @(negedge pclk);
    chk("killed complement", 32'h0, {31'h0, tc_out});
    u_dtc_route_model.put(3, 1'b0);
  endtask : t_rel
  task automatic t_gate_cap();
    logic [31:0] d;
    start(dtc_pkg::DTC_GATED, 3'h0, 1'b1, 1'b0);
    wr(dtc_pkg::ADDR_INT_STAT, 32'h7);
    wr(dtc_pkg::ADDR_INT_MASK, 32'h4);
    u_dtc_route_model.pulse(2);
    repeat (6) @(negedge pclk);
    xfer(1'b0, dtc_pkg::ADDR_CAPTURE, 32'h0, d);
    chk("capture value", 32'h10, d);
    chk("capture irq", 32'h1, {31'h0, irq});
    wr(dtc_pkg::ADDR_INT_STAT, 32'h4);
    @(negedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    xfer(1'b0, dtc_pkg::ADDR_COUNT, 32'h0, d);
    chk("held count", 32'h10, d);
    u_dtc_route_model.put(0, 1'b1);
    repeat (6) @(posedge pclk);
    u_dtc_route_model.put(0, 1'b0);
    repeat (6) @(posedge pclk);
    xfer(1'b0, dtc_pkg::ADDR_COUNT, 32'h0, d);
    chk("counted down", 32'h1, {31'h0, d < 32'h10});
    u_dtc_route_model.pulse(1);
    repeat (6) @(posedge pclk);
    xfer(1'b0, dtc_pkg::ADDR_COUNT, 32'h0, d);
    chk("reset reload", 32'h10, d);
    wr(dtc_pkg::ADDR_INT_MASK, 32'h0);
  endtask : t_gate_cap
  // count terminal pulses; each must last one cycle
  task automatic t_tc(input logic [1:0] m);
    int n;
    logic prev;
    n = 0;
    prev = 1'b0;
    wr(dtc_pkg::ADDR_PERIOD, 32'h3);
    wr(dtc_pkg::ADDR_INT_MASK, 32'h1);
    start(m, 3'h0, 1'b0, 1'b0);
    repeat (40) begin
      @(negedge pclk);
      if (tc_out && prev) chk("tc pulse width", 32'h0, 32'h1);
      if (tc_out && !prev) n++;
      prev = tc_out;
    end
    chk("tc irq", 32'h1, {31'h0, irq});
    if (m == dtc_pkg::DTC_ONESHOT) chk("one shot pulses", 32'h1, n);
    else chk("free run pulses", 32'h1, {31'h0, n >= 8});
    wr(dtc_pkg::ADDR_INT_STAT, 32'h7);
    wr(dtc_pkg::ADDR_CTRL, 32'h0);
  endtask : t_tc
  // prescaled and external edge sources, period FF so no terminal count
  task automatic t_src();
    logic [31:0] d;
    wr(dtc_pkg::ADDR_PERIOD, 32'hFF);
    wr(dtc_pkg::ADDR_PRESCALE, 32'h3);
    wr(dtc_pkg::ADDR_CTRL, 32'h0);
    wr(dtc_pkg::ADDR_CTRL, 32'h101); // prescaled source, free, run
    repeat (40) @(posedge pclk);
    xfer(1'b0, dtc_pkg::ADDR_COUNT, 32'h0, d);
    chk("prescaled count", 32'h1, {31'h0, d >= 32'hF4 && d <= 32'hF6});
    wr(dtc_pkg::ADDR_CTRL, 32'h0);
    wr(dtc_pkg::ADDR_CTRL, 32'h201); // external rising edges, free, run
    repeat (3) begin
      u_dtc_route_model.pulse(4);
      repeat (6) @(posedge pclk);
    end
    xfer(1'b0, dtc_pkg::ADDR_COUNT, 32'h0, d);
    chk("rising ticks", 32'hFC, d);
    wr(dtc_pkg::ADDR_CTRL, 32'h0);
    wr(dtc_pkg::ADDR_CTRL, 32'h301); // external falling edges, free, run
    repeat (3) begin
      u_dtc_route_model.pulse(4);
      repeat (6) @(posedge pclk);
    end
    xfer(1'b0, dtc_pkg::ADDR_COUNT, 32'h0, d);
    chk("falling ticks", 32'hFC, d);
    wr(dtc_pkg::ADDR_CTRL, 32'h0);
    wr(dtc_pkg::ADDR_PRESCALE, 32'h0);
  endtask : t_src
  // complementary pair with a deadband of two ticks; gaps measured once armed
  task automatic t_deadband();
    int lo;
    int runs;
    lo = -1;
    runs = 0;
    wr(dtc_pkg::ADDR_PERIOD, 32'hF);
    wr(dtc_pkg::ADDR_COMPARE, 32'h8);
    wr(dtc_pkg::ADDR_DEADBAND, 32'h2);
    start(dtc_pkg::DTC_FREE, 3'h0, 1'b0, 1'b1);
    repeat (48) begin
      @(negedge pclk);
      if (cmp_out && tc_out) chk("both active", 32'h0, 32'h1);
      if (!cmp_out && !tc_out && lo >= 0) lo++;
      else if (cmp_out || tc_out) begin
        if (lo > 0) begin
          runs++;
          chk("deadband length", 32'h1, {31'h0, lo >= 2 && lo <= 3});
        end
        lo = 0;
      end
    end
    chk("deadband gaps", 32'h1, {31'h0, runs >= 4});
    wr(dtc_pkg::ADDR_DEADBAND, 32'h0);
    wr(dtc_pkg::ADDR_CTRL, 32'h0);
  endtask : t_deadband
  // ----------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rel();
    t_gate_cap();
    t_tc(dtc_pkg::DTC_ONESHOT);
    t_tc(dtc_pkg::DTC_FREE);
    t_src();
    t_deadband();
    give_verdict();
  end
endmodule : down_timer_counter_pwm16_tb
